// ===== cdm_core_mem.v
`timescale 1ns/1ns
`include "cdm_defines.vh"
module cdm_core_mem #(
   parameter RAM_DEPTH = 256
) (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        reset,
   // Direct byte access (address below 80h is RAM)
   input  wire        dirRd,
   input  wire        dirWr,
   input  wire [7:0]  dirAddr,
   input  wire [7:0]  dirWrData,
   // Indirect access through working register 0 or 1
   input  wire        indRd,
   input  wire        indWr,
   input  wire        indSel,
   input  wire [7:0]  indWrData,
   // Bit access, type decided by decoder
   input  wire        bitRd,
   input  wire        bitWr,
   input  wire [7:0]  bitAddr,
   input  wire        bitWrData,
   // Stack operations
   input  wire        pushEn,
   input  wire [7:0]  pushData,
   input  wire        callEn,
   input  wire [15:0] retAddr,
   input  wire        popEn,
   // Pointer decrement opcode
   input  wire        ptrDecEn,
   // ALU results
   input  wire        aluWrAcc,
   input  wire [7:0]  aluAcc,
   input  wire        aluWrB,
   input  wire [7:0]  aluB,
   input  wire        aluFlagWr,
   input  wire        aluCy,
   input  wire        aluAc,
   input  wire        aluOv,
   // Read results
   output reg  [7:0]  rdData,
   output reg         rdBit,
   output reg         rdValid,
   // Architectural state
   output wire [7:0]  accumulator,
   output wire [7:0]  multiplyOperand,
   output wire [7:0]  statusWord,
   output wire [7:0]  stackTopPointer,
   output wire [15:0] dataPointerPair,
   output wire        pointerSelectBit
);
   reg  [7:0]  ram [0:RAM_DEPTH-1];
   reg  [7:0]  stkPtr_r;
   reg  [7:0]  stkPtr_nxt;
   reg  [7:0]  accum_r;
   reg  [7:0]  accum_nxt;
   reg  [7:0]  multOp_r;
   reg  [7:0]  multOp_nxt;
   reg  [7:0]  status_r;
   reg  [7:0]  status_nxt;
   reg         ptrSel_r;
   reg         callHi_r;
   reg  [7:0]  retHi_r;
   wire [15:0] dp0;
   wire [15:0] dp1;
   wire [1:0]  bank;
   wire [7:0]  indPtr;
   wire [7:0]  bitByteAddr;
   wire        bitIsRam;
   wire [2:0]  bitPos;
   wire [7:0]  stkPtrInc;
   wire [7:0]  stkPtrDec;
   reg  [7:0]  sfrRd;
   reg  [7:0]  byteRd;
   reg  [7:0]  bitMerged;
   wire        bitSfrOk;

   assign bank = {status_r[`CDM_ST_BANKHI], status_r[`CDM_ST_BANKLO]};
   // indirect pointer register 0 or 1
   assign indPtr = ram[{3'h0, bank, 2'h0, indSel}];
   assign bitIsRam    = ~bitAddr[7];
   assign bitByteAddr = bitIsRam ? (`CDM_BIT_BASE | {4'h0, bitAddr[6:3]})
                                 : {bitAddr[7:3], 3'h0};
   assign bitPos      = bitAddr[2:0];
   // SFR bits only in the status, accumulator and multiply operand bytes
   assign bitSfrOk = (bitByteAddr == `CDM_SFR_STATUS) |
                     (bitByteAddr == `CDM_SFR_ACCUM)  |
                     (bitByteAddr == `CDM_SFR_MULTOP);
   assign stkPtrInc = stkPtr_r + 8'h01;
   assign stkPtrDec = stkPtr_r - 8'h01;

   always @* begin
      case (dirAddr)
         `CDM_SFR_STACK:  sfrRd = stkPtr_r;
         `CDM_SFR_PTRLO:  sfrRd = ptrSel_r ? dp1[7:0] : dp0[7:0];
         `CDM_SFR_PTRHI:  sfrRd = ptrSel_r ? dp1[15:8] : dp0[15:8];
         `CDM_SFR_AUX2:   sfrRd = {7'h00, ptrSel_r};
         `CDM_SFR_STATUS: sfrRd = status_r;
         `CDM_SFR_ACCUM:  sfrRd = accum_r;
         `CDM_SFR_MULTOP: sfrRd = multOp_r;
         // Unimplemented SFRs read as zero
         default:         sfrRd = 8'h00;
      endcase
   end

   // Byte holding the addressed bit
   always @* begin
      case (bitByteAddr)
         `CDM_SFR_STATUS: byteRd = status_r;
         `CDM_SFR_ACCUM:  byteRd = accum_r;
         `CDM_SFR_MULTOP: byteRd = multOp_r;
         default:         byteRd = ram[bitByteAddr];
      endcase
      bitMerged = byteRd;
      bitMerged[bitPos] = bitWrData;
   end

   // Register write decodes, direct and bit paths
   wire dirSfr    = dirAddr[7];
   wire wrSfr     = dirWr & dirSfr;
   wire bitWrSfr  = bitWr & ~bitIsRam & bitSfrOk;
   wire wrPtrLow  = wrSfr & (dirAddr == `CDM_SFR_PTRLO);
   wire wrPtrHigh = wrSfr & (dirAddr == `CDM_SFR_PTRHI);
   wire wrStack   = wrSfr & (dirAddr == `CDM_SFR_STACK);
   wire wrAccum   = wrSfr & (dirAddr == `CDM_SFR_ACCUM);
   wire wrMultOp  = wrSfr & (dirAddr == `CDM_SFR_MULTOP);
   wire wrStatus  = wrSfr & (dirAddr == `CDM_SFR_STATUS);
   wire wrAuxCtl  = wrSfr & (dirAddr == `CDM_SFR_AUX2);
   wire bitAccum  = bitWrSfr & (bitByteAddr == `CDM_SFR_ACCUM);
   wire bitMultOp = bitWrSfr & (bitByteAddr == `CDM_SFR_MULTOP);
   wire bitStatus = bitWrSfr & (bitByteAddr == `CDM_SFR_STATUS);

   cdm_ptr_word #(.WIDTH(16)) uPtr0 (
      .ref_clk (ref_clk),
      .reset   (reset),
      .wrLow   (wrPtrLow & ~ptrSel_r),
      .wrHigh  (wrPtrHigh & ~ptrSel_r),
      .decEn   (ptrDecEn & ~ptrSel_r),
      .wrData  (dirWrData),
      .value   (dp0)
   );
   cdm_ptr_word #(.WIDTH(16)) uPtr1 (
      .ref_clk (ref_clk),
      .reset   (reset),
      .wrLow   (wrPtrLow & ptrSel_r),
      .wrHigh  (wrPtrHigh & ptrSel_r),
      .decEn   (ptrDecEn & ptrSel_r),
      .wrData  (dirWrData),
      .value   (dp1)
   );

   // Next values of stack pointer and SFRs
   always @* begin
      stkPtr_nxt = stkPtr_r;
      if (pushEn | callEn | callHi_r)
         stkPtr_nxt = stkPtrInc;
      else if (popEn)
         stkPtr_nxt = stkPtrDec;
      else if (wrStack)
         stkPtr_nxt = dirWrData;

      multOp_nxt = multOp_r;
      if (aluWrB)
         multOp_nxt = aluB;
      else if (wrMultOp)
         multOp_nxt = dirWrData;
      else if (bitMultOp)
         multOp_nxt = bitMerged;

      // ALU loads beat software writes
      accum_nxt = accum_r;
      if (aluWrAcc)
         accum_nxt = aluAcc;
      else if (wrAccum)
         accum_nxt = dirWrData;
      else if (bitAccum)
         accum_nxt = bitMerged;

      status_nxt = status_r;
      if (aluFlagWr) begin
         status_nxt[`CDM_ST_CARRY] = aluCy;
         status_nxt[`CDM_ST_AUXCY] = aluAc;
         status_nxt[`CDM_ST_OVFL]  = aluOv;
      end else if (wrStatus)
         status_nxt[7:1] = dirWrData[7:1];
      else if (bitStatus)
         status_nxt[7:1] = bitMerged[7:1];
      status_nxt[`CDM_ST_PARITY] = ^accum_nxt;
   end

   // SFR state and stack pointer
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         stkPtr_r <= `CDM_STACK_RST;
         accum_r  <= `CDM_ZERO_RST;
         multOp_r <= `CDM_ZERO_RST;
         status_r <= `CDM_ZERO_RST;
         ptrSel_r <= 1'h0;
         callHi_r <= 1'h0;
         retHi_r  <= 8'h00;
      end else begin
         stkPtr_r <= stkPtr_nxt;
         accum_r  <= accum_nxt;
         multOp_r <= multOp_nxt;
         status_r <= status_nxt;
         callHi_r <= callEn;
         // High return byte held for second cycle
         if (callEn)
            retHi_r <= retAddr[15:8];
         if (wrAuxCtl)
            ptrSel_r <= dirWrData[`CDM_AUX_PTRSEL];
      end
   end

   // Scratch-pad RAM writes, no reset on contents
   always @(posedge ref_clk) begin
      if (pushEn)
         ram[stkPtrInc] <= pushData;
      else if (callEn)
         ram[stkPtrInc] <= retAddr[7:0];
      else if (callHi_r)
         ram[stkPtrInc] <= retHi_r;
      else if (dirWr & ~dirSfr)
         ram[dirAddr] <= dirWrData;
      else if (indWr)
         ram[indPtr] <= indWrData;
      else if (bitWr & bitIsRam)
         ram[bitByteAddr] <= bitMerged;
   end

   // Registered read results
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdData  <= 8'h00;
         rdBit   <= 1'h0;
         rdValid <= 1'h0;
      end else begin
         rdValid <= dirRd | indRd | bitRd | popEn;
         if (popEn)
            rdData <= ram[stkPtr_r];
         else if (dirRd)
            rdData <= dirSfr ? sfrRd : ram[dirAddr];
         else if (indRd)
            rdData <= ram[indPtr];
         if (bitRd)
            rdBit <= (bitIsRam | bitSfrOk) ? byteRd[bitPos] : 1'h0;
      end
   end

   assign accumulator      = accum_r;
   assign multiplyOperand  = multOp_r;
   assign statusWord       = status_r;
   assign stackTopPointer  = stkPtr_r;
   assign dataPointerPair  = ptrSel_r ? dp1 : dp0;
   assign pointerSelectBit = ptrSel_r;
endmodule // cdm_core_mem

// ===== cdm_defines.vh
`ifndef CDM_DEFINES_VH
`define CDM_DEFINES_VH
// Special function register direct addresses
`define CDM_SFR_STACK   8'h81
`define CDM_SFR_PTRLO   8'h82
`define CDM_SFR_PTRHI   8'h83
`define CDM_SFR_AUX2    8'ha3
`define CDM_SFR_STATUS  8'hd0
`define CDM_SFR_ACCUM   8'he0
`define CDM_SFR_MULTOP  8'hf0
// Reset values
`define CDM_STACK_RST   8'h07
`define CDM_ZERO_RST    8'h00
// Status word bit positions
`define CDM_ST_CARRY    7
`define CDM_ST_AUXCY    6
`define CDM_ST_FLAG0    5
`define CDM_ST_BANKHI   4
`define CDM_ST_BANKLO   3
`define CDM_ST_OVFL     2
`define CDM_ST_FLAG1    1
`define CDM_ST_PARITY   0
// Pointer select bit position
`define CDM_AUX_PTRSEL  0
// Bit area boundaries
`define CDM_BIT_BASE    8'h20
`define CDM_SFR_BASE    8'h80
`endif

// ===== cdm_data_pointer_pair.v
`timescale 1ns/1ns
// One 16-bit data pointer with byte writes and decrement
module cdm_ptr_word #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input  wire             ref_clk,
   input  wire             reset,
   // Control
   input  wire             wrLow,
   input  wire             wrHigh,
   input  wire             decEn,
   input  wire [7:0]       wrData,
   // State
   output wire [WIDTH-1:0] value
);
   reg [WIDTH-1:0] ptr_r;
   reg [WIDTH-1:0] ptr_nxt;

   always @* begin
      ptr_nxt = ptr_r;
      if (decEn)
         ptr_nxt = ptr_r - {{(WIDTH-1){1'h0}}, 1'h1};
      if (wrLow)
         ptr_nxt[7:0] = wrData;
      if (wrHigh)
         ptr_nxt[WIDTH-1:8] = wrData[WIDTH-9:0];
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset)
         ptr_r <= {WIDTH{1'h0}};
      else
         ptr_r <= ptr_nxt;
   end

   assign value = ptr_r;
endmodule // cdm_ptr_word

// ===== cdm_core_checker.sv
`timescale 1ns/1ns
// Stack, pointer and ALU state relations at the top ports
module cdm_core_checker (
   // Clock and reset
   input wire        ref_clk,
   input wire        reset,
   // Requests
   input wire        dirWr,
   input wire        pushEn,
   input wire [7:0]  pushData,
   input wire        callEn,
   input wire        popEn,
   input wire        ptrDecEn,
   input wire        aluWrAcc,
   input wire [7:0]  aluAcc,
   input wire        aluWrB,
   input wire [7:0]  aluB,
   input wire        aluFlagWr,
   input wire        aluCy,
   input wire        aluAc,
   input wire        aluOv,
   // Results and state
   input wire [7:0]  rdData,
   input wire        rdValid,
   input wire [7:0]  accumulator,
   input wire [7:0]  multiplyOperand,
   input wire [7:0]  statusWord,
   input wire [7:0]  stackTopPointer,
   input wire [15:0] dataPointerPair
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire popOnly = popEn && !pushEn && !callEn;
   a_stack_reset_seven: assert property ($fell(reset) |-> stackTopPointer == 8'h07)
      else $error("stack pointer not seven after reset");
   a_push_incr: assert property (pushEn |=> stackTopPointer == $past(stackTopPointer) + 8'h01)
      else $error("push did not step the stack pointer up");
   a_pop_decr: assert property (popOnly |=> rdValid && stackTopPointer == $past(stackTopPointer) - 8'h01)
      else $error("pop did not answer and step down");
   a_pop_returns_push: assert property (pushEn && !callEn ##1 popOnly |=> rdData == $past(pushData, 2))
      else $error("pop after push returned wrong byte");
   a_call_two_bytes: assert property (callEn |=> stackTopPointer == $past(stackTopPointer) + 8'h01
      ##1 stackTopPointer == $past(stackTopPointer, 2) + 8'h02)
      else $error("call did not push two bytes");
   a_acc_load: assert property (aluWrAcc |=> accumulator == $past(aluAcc))
      else $error("accumulator load lost");
   a_mult_operand_load: assert property (aluWrB |=> multiplyOperand == $past(aluB))
      else $error("multiply operand load lost");
   a_flags_recorded: assert property (aluFlagWr |=>
      {statusWord[7:6], statusWord[2]} == $past({aluCy, aluAc, aluOv}))
      else $error("status flags not recorded");
   a_parity_tracks: assert property (statusWord[0] == ^accumulator)
      else $error("parity flag does not match accumulator");
   a_ptr_decrement: assert property (ptrDecEn && !dirWr |=>
      dataPointerPair == $past(dataPointerPair) - 16'h0001)
      else $error("pointer decrement wrong");
   cover property (callEn);
   cover property (pushEn ##1 popOnly);
   cover property (ptrDecEn);
endmodule // cdm_core_checker

bind cdm_core_mem cdm_core_checker chk (.*);

// ===== testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module testbench;
   // Clock and reset
   reg         ref_clk = 1'b0;
   reg         reset   = 1'b1;
   // Requests
   reg         dirRd, dirWr, indRd, indWr, indSel, bitRd, bitWr, bitWrData, pushEn, callEn;
   reg         popEn, ptrDecEn, aluWrAcc, aluWrB, aluFlagWr, aluCy, aluAc, aluOv;
   reg  [7:0]  dirAddr, dirWrData, indWrData, bitAddr, pushData, aluAcc, aluB;
   reg  [15:0] retAddr;
   // Results
   wire [7:0]  rdData, accumulator, multiplyOperand, statusWord, stackTopPointer;
   wire        rdBit, rdValid, pointerSelectBit;
   wire [15:0] dataPointerPair;
   integer     fail_count = 0;
   integer     n_checks   = 0;
   integer     i;

   cdm_core_mem dut (.*);

   always #5 ref_clk = ~ref_clk;

   task final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task idle;
      @(negedge ref_clk);
      {dirRd, dirWr, indRd, indWr, bitRd, bitWr, pushEn, callEn, popEn, ptrDecEn} = 10'h0;
      {aluWrAcc, aluWrB, aluFlagWr} = 3'h0;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(negedge ref_clk);
      dirWr = 1'b1;
      dirAddr = a;
      dirWrData = d;
      idle;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(negedge ref_clk);
      dirRd = 1'b1;
      dirAddr = a;
      idle;
      `CHK("direct read", e, rdData)
   endtask
   task dec;
      @(negedge ref_clk);
      ptrDecEn = 1'b1;
      idle;
   endtask

   task t_stack;
      `CHK("stack reset", 8'h07, stackTopPointer)
      @(negedge ref_clk);
      pushEn = 1'b1;
      pushData = 8'ha5;
      @(negedge ref_clk);
      pushEn = 1'b0;
      popEn = 1'b1;
      `CHK("stack push", 8'h08, stackTopPointer)
      idle;
      `CHK("pop data", 8'ha5, rdData)
      `CHK("stack pop", 8'h07, stackTopPointer)
      rd(8'h08, 8'ha5);
      wr(8'h81, 8'hff);
      @(negedge ref_clk);
      pushEn = 1'b1;
      pushData = 8'h3c;
      idle;
      `CHK("stack wrap", 8'h00, stackTopPointer)
      rd(8'h00, 8'h3c);
   endtask

   task t_call;
      wr(8'h81, 8'h07);
      @(negedge ref_clk);
      callEn = 1'b1;
      retAddr = 16'h1234;
      idle;
      @(negedge ref_clk);
      `CHK("stack call", 8'h09, stackTopPointer)
      rd(8'h08, 8'h34);
      rd(8'h09, 8'h12);
   endtask

   // Each bank points a different upper byte
   task t_banks;
      for (i = 0; i < 4; i++) begin
         wr(i[7:0] * 8'h08 + {7'h0, i[0]}, 8'h90 + i[7:0]);
         wr(8'hd0, i[7:0] << 3);
         @(negedge ref_clk);
         indWr = 1'b1;
         indSel = i[0];
         indWrData = 8'hc0 + i[7:0];
         idle;
      end
      for (i = 0; i < 4; i++) begin
         wr(8'hd0, i[7:0] << 3);
         @(negedge ref_clk);
         indRd = 1'b1;
         indSel = i[0];
         idle;
         `CHK("indirect read", 8'hc0 + i[7:0], rdData)
         rd(8'h90 + i[7:0], 8'h00);
      end
   endtask

   task t_bits;
      wr(8'h21, 8'h00);
      @(negedge ref_clk);
      bitWr = 1'b1;
      bitAddr = 8'h0b;
      bitWrData = 1'b1;
      idle;
      rd(8'h21, 8'h08);
      @(negedge ref_clk);
      bitRd = 1'b1;
      idle;
      `CHK("bit read", 1'b1, rdBit)
      @(negedge ref_clk);
      bitWr = 1'b1;
      bitAddr = 8'he7;
      idle;
      `CHK("accumulator bit", 8'h80, accumulator)
      `CHK("parity", 1'b1, statusWord[0])
   endtask

   task t_ptr;
      wr(8'ha3, 8'h00);
      wr(8'h82, 8'h00);
      wr(8'h83, 8'h01);
      dec;
      `CHK("ptr0 dec", 16'h00ff, dataPointerPair)
      wr(8'ha3, 8'h01);
      `CHK("select", 1'b1, pointerSelectBit)
      `CHK("ptr1", 16'h0000, dataPointerPair)
      dec;
      `CHK("ptr1 dec", 16'hffff, dataPointerPair)
      wr(8'ha3, 8'h00);
      `CHK("ptr0 kept", 16'h00ff, dataPointerPair)
   endtask

   // Software write to the accumulator collides with the ALU load
   task t_alu;
      wr(8'hd0, 8'h00);
      @(negedge ref_clk);
      {aluWrAcc, aluWrB, aluFlagWr, aluCy, aluAc, aluOv} = 6'h3d;
      aluAcc = 8'h03;
      aluB = 8'h5a;
      dirWr = 1'b1;
      dirAddr = 8'he0;
      dirWrData = 8'hff;
      idle;
      `CHK("accumulator", 8'h03, accumulator)
      `CHK("status", 8'h84, statusWord)
      rd(8'hf0, 8'h5a);
      wr(8'hf0, 8'h11);
      rd(8'hf0, 8'h11);
      @(negedge ref_clk);
      bitWr = 1'b1;
      bitAddr = 8'hd3;
      bitWrData = 1'b1;
      idle;
      `CHK("status bit", 8'h8c, statusWord)
   endtask

   initial begin
      {dirRd, dirWr, indRd, indWr, indSel, bitRd, bitWr, bitWrData, pushEn} = 9'h0;
      {callEn, popEn, ptrDecEn, aluWrAcc, aluWrB, aluFlagWr, aluCy, aluAc, aluOv} = 9'h0;
      {dirAddr, dirWrData, indWrData, bitAddr, pushData, aluAcc, aluB, retAddr} = 72'h0;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      t_stack;
      t_call;
      t_banks;
      t_bits;
      t_ptr;
      t_alu;
      final_report;
   end

   initial begin
      #100000;
      fail_count++;
      final_report;
   end
endmodule // testbench
